/* File: common/gpio_pkg.sv */
// Purpose: shared constants and types for the three-port gpio register block
// Assumes: 8-bit core data path, 16-bit data-space address
// Notes:   port index 0 = port b, 1 = port c, 2 = port d
package gpio_pkg;

   localparam int PORT_COUNT = 3;
   localparam int PORT_W     = 8;
   localparam int ADDR_W     = 16;
   localparam int IO_ADDR_W  = 6;

   // ----------------------------------------------------------------
   // address map (data-space offsets)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PORT_B_INPUT_LEVELS = 16'h0023;
   localparam logic [ADDR_W-1:0] OFS_PORT_B_DIRECTION    = 16'h0024;
   localparam logic [ADDR_W-1:0] OFS_PORT_B_OUTPUT_DATA  = 16'h0025;
   localparam logic [ADDR_W-1:0] OFS_PORT_C_INPUT_LEVELS = 16'h0026;
   localparam logic [ADDR_W-1:0] OFS_PORT_C_DIRECTION    = 16'h0027;
   localparam logic [ADDR_W-1:0] OFS_PORT_C_OUTPUT_DATA  = 16'h0028;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_INPUT_LEVELS = 16'h0029;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_DIRECTION    = 16'h002A;
   localparam logic [ADDR_W-1:0] OFS_PORT_D_OUTPUT_DATA  = 16'h002B;

   // short i/o address = data-space offset minus this
   localparam logic [ADDR_W-1:0] IO_SPACE_BASE   = 16'h0020;
   // first data address that short i/o cannot reach
   localparam logic [ADDR_W-1:0] EXT_IO_BASE     = 16'h0060;

   // ----------------------------------------------------------------
   // reset values and unmapped read value
   // ----------------------------------------------------------------
   localparam logic [PORT_W-1:0] RESET_OUTPUT_DATA = 8'h00;
   localparam logic [PORT_W-1:0] RESET_DIRECTION   = 8'h00;
   localparam logic [PORT_W-1:0] RESET_READ_DATA   = 8'h00;
   localparam logic [PORT_W-1:0] UNMAPPED_READ     = 8'h00;

   typedef enum logic [1:0] {
      KIND_NONE,
      KIND_INPUT_LEVELS,
      KIND_DIRECTION,
      KIND_OUTPUT_DATA
   } reg_kind_e;

   typedef struct packed {
      logic [1:0] port;
      reg_kind_e  kind;
   } reg_hit_s;

endpackage

/* File: common/port_ctl_if.sv */
// Purpose: carrier between the register decoder and one port slice
// Assumes: single clock domain, mclk
// Notes:   write strobes are one-cycle pulses
interface port_ctl_if;
   import gpio_pkg::*;

   logic              wr_out;
   logic              wr_dir;
   logic              wr_tgl;
   logic [PORT_W-1:0] wdata;
   logic [PORT_W-1:0] out_q;
   logic [PORT_W-1:0] dir_q;
   logic [PORT_W-1:0] lvl;

   modport ctl   (output wr_out, wr_dir, wr_tgl, wdata, input out_q, dir_q, lvl);
   modport slice (input wr_out, wr_dir, wr_tgl, wdata, output out_q, dir_q, lvl);
endinterface

/* File: hw/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: pins are asynchronous to mclk
// Notes:   first stage feeds the second stage only
module pin_sync
   import gpio_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // levels
   input  wire logic [PORT_W-1:0] async_in,
   output      logic [PORT_W-1:0] sync_out
);
   import gpio_pkg::*;

   logic [PORT_W-1:0] meta;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta     <= RESET_READ_DATA;
         sync_out <= RESET_READ_DATA;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* File: hw/port_slice.sv */
// Purpose: one 8-bit port: output data, direction, pin drive and pull-up
// Assumes: strobes from the decoder are mutually exclusive
// Notes:   pin drive flops load from next values, so pins follow a write at once
module port_slice
   import gpio_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // register side
   port_ctl_if.slice              ctl,
   // global pull-up kill
   input  wire logic              global_pullup_disable,
   // pins
   input  wire logic [PORT_W-1:0] pin_in,
   output      logic [PORT_W-1:0] pin_out,
   output      logic [PORT_W-1:0] pin_oe,
   output      logic [PORT_W-1:0] pullup_en
);
   import gpio_pkg::*;

   logic [PORT_W-1:0] out_q;
   logic [PORT_W-1:0] dir_q;
   logic [PORT_W-1:0] next_out;
   logic [PORT_W-1:0] next_dir;
   logic [PORT_W-1:0] next_pullup;

   // ----------------------------------------------------------------
   // registers and pin drive
   // ----------------------------------------------------------------
   always_comb begin
      next_out = out_q;
      next_dir = dir_q;
      if (ctl.wr_out) begin
         next_out = ctl.wdata;
      end
      if (ctl.wr_tgl) begin
         next_out = out_q ^ ctl.wdata;
      end
      if (ctl.wr_dir) begin
         next_dir = ctl.wdata;
      end
      // input with data bit set pulls up unless globally killed
      next_pullup = ~next_dir & next_out & {PORT_W{~global_pullup_disable}};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_q     <= RESET_OUTPUT_DATA;
         dir_q     <= RESET_DIRECTION;
         pin_out   <= RESET_OUTPUT_DATA;
         pin_oe    <= RESET_DIRECTION;
         pullup_en <= RESET_OUTPUT_DATA;
      end else begin
         out_q     <= next_out;
         dir_q     <= next_dir;
         pin_out   <= next_out;
         pin_oe    <= next_dir;
         pullup_en <= next_pullup;
      end
   end

   assign ctl.out_q = out_q;
   assign ctl.dir_q = dir_q;

   // ----------------------------------------------------------------
   // sampled pin levels
   // ----------------------------------------------------------------
   pin_sync u_sync (
      .mclk     (mclk),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (ctl.lvl)
   );
endmodule

/* File: hw/gpio_ports.sv */
// Purpose: register decode and read-back for gpio ports b, c and d
// Assumes: core issues at most one access per cycle, on mclk
// Notes:   read data registered one cycle after the read strobe

module gpio_ports
   import gpio_pkg::*;
(
   // clock and reset
   input  wire logic                                 mclk,
   input  wire logic                                 rst,
   // core access
   input  wire logic [gpio_pkg::ADDR_W-1:0]          core_addr,
   input  wire logic                                 core_io,
   input  wire logic                                 core_wr,
   input  wire logic                                 core_rd,
   input  wire logic [gpio_pkg::PORT_W-1:0]          core_wdata,
   output      logic [gpio_pkg::PORT_W-1:0]          core_rdata,
   // global pull-up kill
   input  wire logic                                 global_pullup_disable,
   // pins, index 0 = b, 1 = c, 2 = d
   input  wire logic [2:0][gpio_pkg::PORT_W-1:0]     pin_in,
   output      logic [2:0][gpio_pkg::PORT_W-1:0]     pin_out,
   output      logic [2:0][gpio_pkg::PORT_W-1:0]     pin_oe,
   output      logic [2:0][gpio_pkg::PORT_W-1:0]     pullup_en
);
   import gpio_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic reg_hit_s decode(input logic [ADDR_W-1:0] addr);
      reg_hit_s h;
      h.port = 2'd0;
      h.kind = KIND_NONE;
      case (addr)
         OFS_PORT_B_INPUT_LEVELS: h = '{2'd0, KIND_INPUT_LEVELS};
         OFS_PORT_B_DIRECTION:    h = '{2'd0, KIND_DIRECTION};
         OFS_PORT_B_OUTPUT_DATA:  h = '{2'd0, KIND_OUTPUT_DATA};
         OFS_PORT_C_INPUT_LEVELS: h = '{2'd1, KIND_INPUT_LEVELS};
         OFS_PORT_C_DIRECTION:    h = '{2'd1, KIND_DIRECTION};
         OFS_PORT_C_OUTPUT_DATA:  h = '{2'd1, KIND_OUTPUT_DATA};
         OFS_PORT_D_INPUT_LEVELS: h = '{2'd2, KIND_INPUT_LEVELS};
         OFS_PORT_D_DIRECTION:    h = '{2'd2, KIND_DIRECTION};
         OFS_PORT_D_OUTPUT_DATA:  h = '{2'd2, KIND_OUTPUT_DATA};
         default:                 h = '{2'd0, KIND_NONE};
      endcase
      return h;
   endfunction

   // short i/o address to data-space address; upper bits set means out of reach
   function automatic logic [ADDR_W-1:0] to_data_addr(input logic [ADDR_W-1:0] addr,
                                                      input logic              io);
      logic [ADDR_W-1:0] a;
      a = addr;
      if (io) begin
         if (addr[ADDR_W-1:IO_ADDR_W] != '0) begin
            a = EXT_IO_BASE;
         end else begin
            a = addr + IO_SPACE_BASE;
         end
      end
      return a;
   endfunction

   logic [ADDR_W-1:0] data_addr;
   reg_hit_s          hit;

   always_comb begin
      data_addr = to_data_addr(core_addr, core_io);
      hit       = decode(data_addr);
   end

   // ----------------------------------------------------------------
   // per-port slices
   // ----------------------------------------------------------------
   port_ctl_if pc [PORT_COUNT] ();

   logic [PORT_COUNT-1:0][PORT_W-1:0] out_q;
   logic [PORT_COUNT-1:0][PORT_W-1:0] dir_q;
   logic [PORT_COUNT-1:0][PORT_W-1:0] lvl;

   for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
      logic sel;
      assign sel          = (hit.port == 2'(p)) && (hit.kind != KIND_NONE);
      assign pc[p].wdata  = core_wdata;
      assign pc[p].wr_out = core_wr && sel && (hit.kind == KIND_OUTPUT_DATA);
      assign pc[p].wr_dir = core_wr && sel && (hit.kind == KIND_DIRECTION);
      assign pc[p].wr_tgl = core_wr && sel && (hit.kind == KIND_INPUT_LEVELS);
      assign out_q[p]     = pc[p].out_q;
      assign dir_q[p]     = pc[p].dir_q;
      assign lvl[p]       = pc[p].lvl;

      port_slice u_slice (
         .mclk                  (mclk),
         .rst                   (rst),
         .ctl                   (pc[p]),
         .global_pullup_disable (global_pullup_disable),
         .pin_in                (pin_in[p]),
         .pin_out               (pin_out[p]),
         .pin_oe                (pin_oe[p]),
         .pullup_en             (pullup_en[p])
      );
   end

   // ----------------------------------------------------------------
   // read-back
   // ----------------------------------------------------------------
   logic [PORT_W-1:0] next_rdata;

   always_comb begin
      next_rdata = core_rdata;
      if (core_rd) begin
         case (hit.kind)
            KIND_INPUT_LEVELS: next_rdata = lvl[hit.port];
            KIND_DIRECTION:    next_rdata = dir_q[hit.port];
            KIND_OUTPUT_DATA:  next_rdata = out_q[hit.port];
            default:           next_rdata = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         core_rdata <= RESET_READ_DATA;
      end else begin
         core_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic first_cycle;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         first_cycle <= 1'b1;
      end else begin
         first_cycle <= 1'b0;
      end
   end

   property p_io_alias;
      core_wr && core_io && core_addr == OFS_PORT_B_DIRECTION - IO_SPACE_BASE
      |=> dir_q[0] == $past(core_wdata) && pin_oe[0] == $past(core_wdata);
   endproperty
   a_io_alias: assert property (p_io_alias)
      else $error("short i/o write to port b direction lost");

   property p_io_read_alias;
      core_rd && core_io && core_addr == OFS_PORT_D_OUTPUT_DATA - IO_SPACE_BASE
      |=> core_rdata == $past(out_q[2]);
   endproperty
   a_io_read_alias: assert property (p_io_read_alias)
      else $error("short i/o read of port d output data wrong");

   property p_ext_blocked;
      core_wr && core_io && core_addr[ADDR_W-1:IO_ADDR_W] != '0
      |=> $stable(out_q) && $stable(dir_q);
   endproperty
   a_ext_blocked: assert property (p_ext_blocked)
      else $error("short i/o beyond 0x3f changed a port register");

   property p_toggle;
      core_wr && !core_io && core_addr == OFS_PORT_C_INPUT_LEVELS
      |=> out_q[1] == ($past(out_q[1]) ^ $past(core_wdata)) && $stable(dir_q[1]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("input-level write did not toggle port c output data");

   property p_reset_clear;
      first_cycle |-> out_q == '0 && dir_q == '0 && pin_oe == '0 && pullup_en == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("port registers not clear after reset");

   property p_level_read;
      core_rd && !core_io && core_addr == OFS_PORT_B_INPUT_LEVELS
      |=> core_rdata == $past(lvl[0]);
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("input-level read does not return sampled pins");

   property p_pin_sample;
      !first_cycle |-> ##2 lvl[2] == $past(pin_in[2], 2);
   endproperty
   a_pin_sample: assert property (p_pin_sample)
      else $error("sampled levels not two cycles behind pins");

   property p_dir_bitwise;
      core_wr && !core_io && core_addr == OFS_PORT_D_DIRECTION
      |=> pin_oe[2] == $past(core_wdata) ##1 pin_oe[2] == dir_q[2];
   endproperty
   a_dir_bitwise: assert property (p_dir_bitwise)
      else $error("port d pin enables do not follow direction write");

   property p_pullup;
      ##1 pullup_en[0] == (~pin_oe[0] & pin_out[0] & {PORT_W{~$past(global_pullup_disable)}});
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("port b pull-up enables wrong");

   property p_drive;
      core_wr && !core_io && core_addr == OFS_PORT_C_OUTPUT_DATA
      |=> pin_out[1] == $past(core_wdata) && $stable(pin_oe[1]);
   endproperty
   a_drive: assert property (p_drive)
      else $error("port c drive does not match data and direction");

   property p_unmapped;
      core_rd && hit.kind == KIND_NONE |=> core_rdata == UNMAPPED_READ;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   property p_io_write_out;
      core_wr && core_io && core_addr == OFS_PORT_B_OUTPUT_DATA - IO_SPACE_BASE
      |=> out_q[0] == $past(core_wdata) && pin_out[0] == $past(core_wdata);
   endproperty
   a_io_write_out: assert property (p_io_write_out)
      else $error("short i/o write to port b output data lost");

   property p_ext_read;
      core_rd && core_io && core_addr[ADDR_W-1:IO_ADDR_W] != '0
      |=> core_rdata == UNMAPPED_READ;
   endproperty
   a_ext_read: assert property (p_ext_read)
      else $error("short i/o read beyond 0x3f returned data");

   property p_toggle_b;
      core_wr && !core_io && core_addr == OFS_PORT_B_INPUT_LEVELS
      |=> pin_out[0] == ($past(out_q[0]) ^ $past(core_wdata)) && $stable(dir_q[0]);
   endproperty
   a_toggle_b: assert property (p_toggle_b)
      else $error("input-level write did not toggle port b pins");

   property p_reset_outputs;
      first_cycle |-> core_rdata == RESET_READ_DATA && pin_out == '0;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("read data or pin drive not clear after reset");

   property p_dir_read;
      core_rd && !core_io && core_addr == OFS_PORT_D_DIRECTION
      |=> core_rdata == $past(dir_q[2]);
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("port d direction read back wrong");

   property p_level_read_c;
      core_rd && !core_io && core_addr == OFS_PORT_C_INPUT_LEVELS
      |=> core_rdata == $past(lvl[1]);
   endproperty
   a_level_read_c: assert property (p_level_read_c)
      else $error("port c input-level read does not return sampled pins");

   property p_io_level_read_d;
      core_rd && core_io && core_addr == OFS_PORT_D_INPUT_LEVELS - IO_SPACE_BASE
      |=> core_rdata == $past(lvl[2]);
   endproperty
   a_io_level_read_d: assert property (p_io_level_read_d)
      else $error("short i/o read of port d input levels wrong");

   property p_dir_per_port;
      core_wr && !core_io && core_addr == OFS_PORT_C_DIRECTION
      |=> pin_oe[1] == $past(core_wdata) && $stable(pin_oe[0]) && $stable(pin_oe[2]);
   endproperty
   a_dir_per_port: assert property (p_dir_per_port)
      else $error("port c direction write disturbed other ports");

   property p_pullup_d;
      ##1 pullup_en[2] == (~pin_oe[2] & pin_out[2] & {PORT_W{~$past(global_pullup_disable)}});
   endproperty
   a_pullup_d: assert property (p_pullup_d)
      else $error("port d pull-up enables wrong");

   property p_pullup_kill;
      global_pullup_disable |=> pullup_en == '0;
   endproperty
   a_pullup_kill: assert property (p_pullup_kill)
      else $error("pull-up left on while globally disabled");

   property p_dir_release;
      core_wr && !core_io && core_addr == OFS_PORT_B_DIRECTION
      |=> pin_oe[0] == $past(core_wdata) && $stable(pin_out[0]);
   endproperty
   a_dir_release: assert property (p_dir_release)
      else $error("port b drive enables do not follow direction");

   property p_unmapped_write;
      core_wr && hit.kind == KIND_NONE |=> $stable(out_q) && $stable(dir_q);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write changed a port register");

   c_toggle:   cover property (core_wr && hit.kind == KIND_INPUT_LEVELS && core_wdata != '0);
   c_io_write: cover property (core_wr && core_io && hit.kind == KIND_DIRECTION);
   c_pullup:   cover property (pullup_en[0] != '0 ##1 global_pullup_disable);
   c_ext_io:   cover property (core_rd && core_io && core_addr[ADDR_W-1:IO_ADDR_W] != '0);
endmodule

/* File: dv/pin_world.sv */
// Purpose: far side of the port pins: external drivers, pull-ups, floating lines
// Assumes: one external driver per pin, enabled by ext_en
// Notes:   a floating pin shows the inverse of its last level each cycle
module pin_world
   import gpio_pkg::*;
(
   // clock
   input  wire logic                       mclk,
   // device pin side
   input  wire logic [2:0][PORT_W-1:0]     pin_out,
   input  wire logic [2:0][PORT_W-1:0]     pin_oe,
   input  wire logic [2:0][PORT_W-1:0]     pullup_en,
   // external drivers
   input  wire logic [2:0][PORT_W-1:0]     ext_en,
   input  wire logic [2:0][PORT_W-1:0]     ext_lvl,
   // resolved levels
   output      logic [2:0][PORT_W-1:0]     pin_in
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [2:0][PORT_W-1:0] last = '0;

   always_ff @(posedge mclk) begin
      last <= pin_in;
   end

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            if (pin_oe[p][b]) begin
               pin_in[p][b] = pin_out[p][b];
            end else if (ext_en[p][b]) begin
               pin_in[p][b] = ext_lvl[p][b];
            end else if (pullup_en[p][b]) begin
               pin_in[p][b] = 1'b1;
            end else begin
               pin_in[p][b] = ~last[p][b];
            end
         end
      end
   end
endmodule

/* File: dv/gpio_ports_tb.sv */
// Purpose: self-checking bench for the gpio port register block
// Assumes: one access at a time, idle cycle between accesses
// Notes:   port index 0 = b, 1 = c, 2 = d
module gpio_ports_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import gpio_pkg::*;

   logic                   mclk = 1'b0;
   logic                   rst = 1'b1;
   logic [ADDR_W-1:0]      core_addr = '0;
   logic                   core_io = 1'b0;
   logic                   core_wr = 1'b0;
   logic                   core_rd = 1'b0;
   logic [PORT_W-1:0]      core_wdata = '0;
   logic [PORT_W-1:0]      core_rdata;
   logic                   global_pullup_disable = 1'b0;
   logic [2:0][PORT_W-1:0] pin_in;
   logic [2:0][PORT_W-1:0] pin_out;
   logic [2:0][PORT_W-1:0] pin_oe;
   logic [2:0][PORT_W-1:0] pullup_en;
   logic [2:0][PORT_W-1:0] ext_en = '0;
   logic [2:0][PORT_W-1:0] ext_lvl = '0;
   logic [PORT_W-1:0]      v;
   int                     bad_count = 0;
   int                     compares = 0;

   gpio_ports u_gpio_ports (.mclk(mclk), .rst(rst), .core_addr(core_addr), .core_io(core_io),
      .core_wr(core_wr), .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
      .global_pullup_disable(global_pullup_disable), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en));

   pin_world u_pin_world (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_en(pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   // data-space offset: kind 0 levels, 1 direction, 2 output data
   function automatic logic [ADDR_W-1:0] ofs(input int p, input int k);
      return 16'h0023 + 16'(3 * p + k);
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic io, input logic [7:0] d);
      @(posedge mclk);
      core_addr <= a;
      core_io <= io;
      core_wdata <= d;
      core_wr <= 1'b1;
      @(posedge mclk);
      core_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic io, input logic [7:0] e, input string n);
      @(posedge mclk);
      core_addr <= a;
      core_io <= io;
      core_rd <= 1'b1;
      @(posedge mclk);
      core_rd <= 1'b0;
      #1;
      chk(n, e, core_rdata);
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         rd(ofs(p, 1), 1'b0, 8'h00, "direction reset");
         rd(ofs(p, 2), 1'b0, 8'h00, "output reset");
         chk("pin_oe reset", 8'h00, pin_oe[p]);
      end
      $display("test reset done");
      for (int p = 0; p < 3; p++) begin
         for (int k = 1; k < 3; k++) begin
            v = 8'h13 * 8'(p * 2 + k);
            wr(ofs(p, k), 1'b0, v);
            rd(ofs(p, k) - 16'h0020, 1'b1, v, "short read");
            wr(ofs(p, k) - 16'h0020, 1'b1, ~v);
            rd(ofs(p, k), 1'b0, ~v, "data read");
         end
      end
      $display("test map done");
      wr(16'h0044, 1'b1, 8'hFF);
      rd(ofs(0, 1), 1'b0, ~(8'h13), "short write above range");
      rd(16'h0044, 1'b1, 8'h00, "short read above range");
      wr(16'h002C, 1'b0, 8'hFF);
      rd(16'h002C, 1'b0, 8'h00, "unmapped read");
      $display("test range done");
      for (int p = 0; p < 3; p++) begin
         wr(ofs(p, 1), 1'b0, 8'hFF);
         wr(ofs(p, 2), 1'b0, 8'h5A);
         wr(ofs(p, 0), 1'b0, 8'h81);
         rd(ofs(p, 2), 1'b0, 8'hDB, "toggled output");
         chk("toggled pin", 8'hDB, pin_out[p]);
      end
      $display("test toggle done");
      for (int p = 0; p < 3; p++) begin
         ext_en[p] <= 8'h0F;
         ext_lvl[p] <= 8'h0C;
         wr(ofs(p, 1), 1'b0, 8'hF0);
         wr(ofs(p, 2), 1'b0, 8'hA5);
         repeat (3) @(posedge mclk);
         #1;
         chk("pin_oe", 8'hF0, pin_oe[p]);
         chk("pin_out", 8'hA5, pin_out[p]);
         chk("pullup", 8'h05, pullup_en[p]);
         rd(ofs(p, 0), 1'b0, 8'hAC, "levels");
         @(posedge mclk);
         global_pullup_disable <= 1'b1;
         repeat (2) @(posedge mclk);
         #1;
         chk("pullup off", 8'h00, pullup_en[p]);
         @(posedge mclk);
         global_pullup_disable <= 1'b0;
         ext_en[p] <= 8'h00;
         wr(ofs(p, 2), 1'b0, 8'hAF);
         repeat (3) @(posedge mclk);
         rd(ofs(p, 0) - 16'h0020, 1'b1, 8'hAF, "pulled levels");
      end
      $display("test pins done");
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("pin_oe second reset", 8'h00, pin_oe[2]);
      rd(ofs(1, 2), 1'b0, 8'h00, "output second reset");
      $display("test second reset done");
      end_sim;
   end

   initial begin
      #(25 * 20000);
      bad_count++;
      $display("unexpected watchdog expected done seen hang");
      end_sim;
   end
endmodule
